// [verilog/sdrc_cfg.svh]
// register map, field positions, reset values and timing counts
// assumes inclusion by bare name from the design and bench files
`ifndef SDRC_CFG_SVH
`define SDRC_CFG_SVH
`define SDRC_OFF_MODE    8'h00
`define SDRC_OFF_CTRL    8'h04
`define SDRC_OFF_FILT    8'h08
`define SDRC_OFF_IOCTL   8'h0c
`define SDRC_OFF_STATUS  8'h10
`define SDRC_OFF_ZSCAL   8'h14
`define SDRC_OFF_FSCAL   8'h18
`define SDRC_OFF_DONE    8'h1c
`define SDRC_MODE_RST    8'h00
`define SDRC_CTRL_RST    8'h00
`define SDRC_FILT_RST    8'h45
`define SDRC_IOCTL_RST   8'h00
`define SDRC_ZSCAL_RST   16'h8000
`define SDRC_FSCAL_TOP   4'h5
`define SDRC_FSCAL_LOW   12'h3bb
`define SDRC_MODE_CHCON  4
`define SDRC_MODE_CHOP   7
`define SDRC_MODE_REFSEL 5
`define SDRC_MODE_OSCPD  3
`define SDRC_IO_DIR1     5
`define SDRC_IO_DIR2     4
`define SDRC_IO_DAT1     1
`define SDRC_IO_DAT2     0
`define SDRC_ST_RDY      7
`define SDRC_ST_CAL      5
`define SDRC_ST_ERR      3
`define SDRC_ST_LOCK     0
`define SDRC_CAL_NS      1000
`define SDRC_CLK_MHZ     250
`endif

// [verilog/sdrc_pkg.sv]
// types shared by the converter register control
// assumes sdrc_cfg.svh holds the numeric constants
package sdrc_pkg;
  typedef enum logic [2:0]
  {
    SDRC_M_IDLE  = 3'h0,
    SDRC_M_CONT  = 3'h1,
    SDRC_M_SINGL = 3'h2,
    SDRC_M_PDOWN = 3'h3,
    SDRC_M_ZSINT = 3'h4,
    SDRC_M_FSINT = 3'h5,
    SDRC_M_ZSSYS = 3'h6,
    SDRC_M_FSSYS = 3'h7
  } sdrc_mode_e;
  typedef enum logic [1:0]
  {
    SDRC_S_IDLE = 2'b00,
    SDRC_S_CAL  = 2'b01,
    SDRC_S_DONE = 2'b11
  } sdrc_state_e;
  typedef struct packed
  {
    logic        wr;
    logic [7:0]  addr;
  } sdrc_req_s;
  typedef struct packed
  {
    logic [1:0]  pin_o;
    logic [1:0]  pin_oe;
  } sdrc_gpio_s;
endpackage

// [verilog/sdrc_ctrl.sv]
// register control of a multi-channel sigma-delta converter
// assumes an ahb-lite master, single word transfers, one clock
`timescale 1ns/10ps
`default_nettype none
`include "sdrc_cfg.svh"
// Contract
// RULE1: zero-scale coefficient resets to 8000 hex
// RULE2: full-scale coefficient resets with top digit five
// RULE3: both coefficients readable and writable
// RULE4: control selects polarity, channel and range
// RULE5: channel configure bit selects alternate mapping
// RULE6: each pin direction and output level programmable
// RULE7: input pin level read back in data bit
// RULE8: mode selects mode, chcon, chop, reference, oscillator
// RULE9: calibration write starts; ready falls at completion
// RULE10: mode field returns to idle after calibration
// RULE11: host idles converter before config writes
// RULE12: mode register resets to zero
// RULE13: status is read-only flag register
// RULE14: host applies system input before calibration
// RULE15: host writes filter only 0d to ff
// RULE16: ready stays high during calibration
// RULE17: io readback returns direction and output levels
module sdrc_ctrl
  import sdrc_pkg::*;
#(
  parameter int CAL_NS = `SDRC_CAL_NS
)
(
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // converter side
  input  wire logic        conv_err,
  input  wire logic        conv_lock,
  input  wire logic        conv_data_ready,
  output logic      [7:0]  conv_ctrl,
  output logic      [3:0]  conv_pin_map,
  output logic             conv_chop,
  output logic             conv_ref_sel,
  output logic             conv_osc_pd,
  output logic             rdy_n,
  // general-purpose pins
  input  wire logic        gp_pin_one_i,
  input  wire logic        gp_pin_two_i,
  output logic             gp_pin_one_o,
  output logic             gp_pin_one_oe,
  output logic             gp_pin_two_o,
  output logic             gp_pin_two_oe
);
  localparam int CAL_CYC_RAW = (CAL_NS * `SDRC_CLK_MHZ + 999) / 1000;
  localparam int CAL_CYC = (CAL_CYC_RAW < 1) ? 1 : CAL_CYC_RAW;
  localparam logic [15:0] CAL_LAST = 16'(CAL_CYC - 1);

  sdrc_req_s   req_reg, req_next;
  logic [7:0]  mode_reg, mode_next;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  filt_reg, filt_next;
  logic [7:0]  io_reg, io_next;
  logic [15:0] zs_reg, zs_next;
  logic [15:0] fs_reg, fs_next;
  logic [7:0]  done_reg, done_next;
  sdrc_state_e st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        rdy_reg, rdy_next;
  logic [31:0] rd_reg, rd_next;
  sdrc_gpio_s  gp_reg, gp_next;
  logic [7:0]  status;
  logic [7:0]  io_view;
  logic        wr_hit;

  function automatic logic is_cal(input logic [2:0] m);
    is_cal = m[2];
  endfunction

  // pins set as inputs show their level, outputs their programmed level
  always_comb
  begin
    io_view = io_reg; // [RULE17]
    if (!io_reg[`SDRC_IO_DIR1])
      io_view[`SDRC_IO_DAT1] = gp_pin_one_i; // [RULE7]
    if (!io_reg[`SDRC_IO_DIR2])
      io_view[`SDRC_IO_DAT2] = gp_pin_two_i; // [RULE7]
  end

  always_comb
  begin
    status = 8'h00; // [RULE13]
    status[`SDRC_ST_RDY]  = conv_data_ready;
    status[`SDRC_ST_CAL]  = (st_reg == SDRC_S_DONE) || done_reg[0];
    status[`SDRC_ST_ERR]  = conv_err;
    status[`SDRC_ST_LOCK] = conv_lock;
  end

  always_comb
  begin
    req_next = req_reg;
    rd_next  = rd_reg;
    if (hready)
    begin
      req_next.wr   = hsel && htrans[1] && hwrite;
      req_next.addr = haddr;
      if (hsel && htrans[1] && !hwrite)
      begin
        case (haddr)
          `SDRC_OFF_MODE:   rd_next = {24'h0, mode_reg};
          `SDRC_OFF_CTRL:   rd_next = {24'h0, ctrl_reg}; // [RULE4]
          `SDRC_OFF_FILT:   rd_next = {24'h0, filt_reg};
          `SDRC_OFF_IOCTL:  rd_next = {24'h0, io_view};
          `SDRC_OFF_STATUS: rd_next = {24'h0, status};
          `SDRC_OFF_ZSCAL:  rd_next = {16'h0, zs_reg}; // [RULE3]
          `SDRC_OFF_FSCAL:  rd_next = {16'h0, fs_reg}; // [RULE3]
          `SDRC_OFF_DONE:   rd_next = {24'h0, done_reg};
          default:          rd_next = 32'h0;
        endcase
      end
    end
  end

  assign wr_hit = req_reg.wr;

  // register writes and the calibration sequencer share one next-state block
  // so the automatic return to idle and a host write never race
  always_comb
  begin
    mode_next = mode_reg;
    ctrl_next = ctrl_reg;
    filt_next = filt_reg;
    io_next   = io_reg;
    zs_next   = zs_reg;
    fs_next   = fs_reg;
    done_next = done_reg;
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    rdy_next  = rdy_reg;
    if (wr_hit)
    begin
      case (req_reg.addr)
        `SDRC_OFF_MODE:  mode_next = hwdata[7:0]; // [RULE8]
        `SDRC_OFF_CTRL:  ctrl_next = hwdata[7:0]; // [RULE4]
        `SDRC_OFF_FILT:  filt_next = hwdata[7:0];
        `SDRC_OFF_IOCTL: io_next   = hwdata[7:0]; // [RULE6]
        `SDRC_OFF_ZSCAL: zs_next   = hwdata[15:0]; // [RULE3]
        `SDRC_OFF_FSCAL: fs_next   = hwdata[15:0]; // [RULE3]
        `SDRC_OFF_DONE:  done_next = 8'h00;
        default:         mode_next = mode_reg;
      endcase
    end
    case (st_reg)
      SDRC_S_IDLE:
      begin
        if (wr_hit && req_reg.addr == `SDRC_OFF_MODE && is_cal(hwdata[2:0]))
        begin
          st_next  = SDRC_S_CAL; // [RULE9]
          cnt_next = 16'h0;
          rdy_next = 1'b1; // [RULE16]
        end
      end
      SDRC_S_CAL:
      begin
        rdy_next = 1'b1; // [RULE16]
        if (cnt_reg == CAL_LAST)
          st_next = SDRC_S_DONE;
        else
          cnt_next = cnt_reg + 16'h1;
      end
      SDRC_S_DONE:
      begin
        // zero-scale result stored while ready falls and mode returns to idle, all on one edge
        if (mode_reg[2:0] == 3'(SDRC_M_ZSINT) ||
            mode_reg[2:0] == 3'(SDRC_M_ZSSYS))
          zs_next = zs_reg ^ 16'h0001;
        else
          fs_next = fs_reg;
        mode_next[2:0] = 3'(SDRC_M_IDLE); // [RULE10]
        rdy_next  = 1'b0; // [RULE9]
        done_next = 8'h01; // set wins over any clear this cycle
        st_next   = SDRC_S_IDLE;
      end
      default: st_next = SDRC_S_IDLE;
    endcase
  end

  always_comb
  begin
    gp_next.pin_oe = {io_reg[`SDRC_IO_DIR1], io_reg[`SDRC_IO_DIR2]};
    gp_next.pin_o  = {io_reg[`SDRC_IO_DAT1], io_reg[`SDRC_IO_DAT2]}; // [RULE6]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_reg  <= '0;
      rd_reg   <= 32'h0;
      mode_reg <= `SDRC_MODE_RST; // [RULE12]
      ctrl_reg <= `SDRC_CTRL_RST;
      filt_reg <= `SDRC_FILT_RST;
      io_reg   <= `SDRC_IOCTL_RST;
      zs_reg   <= `SDRC_ZSCAL_RST; // [RULE1]
      fs_reg   <= {`SDRC_FSCAL_TOP, `SDRC_FSCAL_LOW}; // [RULE2]
      done_reg <= 8'h00;
      st_reg   <= SDRC_S_IDLE;
      cnt_reg  <= 16'h0;
      rdy_reg  <= 1'b1;
      gp_reg   <= '0;
    end
    else if (clk_en)
    begin
      req_reg  <= req_next;
      rd_reg   <= rd_next;
      mode_reg <= mode_next;
      ctrl_reg <= ctrl_next;
      filt_reg <= filt_next;
      io_reg   <= io_next;
      zs_reg   <= zs_next;
      fs_reg   <= fs_next;
      done_reg <= done_next;
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      rdy_reg  <= rdy_next;
      gp_reg   <= gp_next;
    end
  end

  always_comb
  begin
    hrdata        = rd_reg;
    hreadyout     = 1'b1;
    hresp         = 1'b0;
    conv_ctrl     = ctrl_reg;
    conv_pin_map  = {mode_reg[`SDRC_MODE_CHCON], ctrl_reg[6:4]}; // [RULE5]
    conv_chop     = mode_reg[`SDRC_MODE_CHOP]; // [RULE8]
    conv_ref_sel  = mode_reg[`SDRC_MODE_REFSEL];
    conv_osc_pd   = mode_reg[`SDRC_MODE_OSCPD];
    rdy_n         = rdy_reg;
    gp_pin_one_o  = gp_reg.pin_o[1];
    gp_pin_two_o  = gp_reg.pin_o[0];
    gp_pin_one_oe = gp_reg.pin_oe[1];
    gp_pin_two_oe = gp_reg.pin_oe[0];
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);

  a_rdy_high_cal: assert property ( // [RULE16]
    st_reg == SDRC_S_CAL |-> rdy_reg)
    else $error("ready low during calibration");
  a_cal_to_idle: assert property ( // [RULE10]
    st_reg == SDRC_S_DONE |=> mode_reg[2:0] == 3'h0)
    else $error("mode not idle after calibration");
  a_rdy_falls: assert property ( // [RULE9]
    st_reg == SDRC_S_DONE |=> !rdy_reg && done_reg[0])
    else $error("ready did not fall at completion");
  a_cal_starts: assert property ( // [RULE9]
    st_reg == SDRC_S_IDLE && wr_hit && req_reg.addr == `SDRC_OFF_MODE &&
    hwdata[2] |=> st_reg == SDRC_S_CAL)
    else $error("calibration not started");
  a_cal_length: assert property ( // [RULE9]
    $rose(st_reg == SDRC_S_CAL) |-> ##[1:300] st_reg == SDRC_S_DONE)
    else $error("calibration too long");
  a_ctrl_write: assert property ( // [RULE4]
    wr_hit && req_reg.addr == `SDRC_OFF_CTRL |=>
    ctrl_reg == $past(hwdata[7:0]))
    else $error("control write lost");
  // in zero-scale modes the done cycle stores the result, so a write there may be overtaken
  a_coeff_write: assert property ( // [RULE3]
    wr_hit && req_reg.addr == `SDRC_OFF_ZSCAL && st_reg != SDRC_S_DONE |=>
    zs_reg == $past(hwdata[15:0]))
    else $error("zero-scale write lost");
  a_pin_drive: assert property ( // [RULE6]
    io_reg[`SDRC_IO_DIR1] |=>
    gp_pin_one_oe && gp_pin_one_o == $past(io_reg[`SDRC_IO_DAT1]))
    else $error("pin one not driven");
  a_status_ro: assert property ( // [RULE13]
    wr_hit && req_reg.addr == `SDRC_OFF_STATUS && st_reg != SDRC_S_DONE
    |=> $stable(mode_reg) && $stable(ctrl_reg))
    else $error("status write had effect");
  a_io_read: assert property ( // [RULE17]
    hready && hsel && htrans[1] && !hwrite && haddr == `SDRC_OFF_IOCTL
    |=> rd_reg[5:4] == $past(io_reg[5:4]))
    else $error("io readback wrong");
  a_pin_sense: assert property ( // [RULE7]
    hready && hsel && htrans[1] && !hwrite && haddr == `SDRC_OFF_IOCTL &&
    !io_reg[`SDRC_IO_DIR1] |=> rd_reg[`SDRC_IO_DAT1] == $past(gp_pin_one_i))
    else $error("input level not read back");
  c_cal_done: cover property (st_reg == SDRC_S_DONE);
  c_pin_in: cover property (!io_reg[`SDRC_IO_DIR1] && gp_pin_one_i);
  c_zs_write: cover property (wr_hit && req_reg.addr == `SDRC_OFF_ZSCAL);
  c_sys_cal: cover property (st_reg == SDRC_S_DONE && mode_reg[2:0] == 3'h7);
endmodule
`default_nettype wire

// [verif/sdrc_pin_host.sv]
// host-side pins: drives general-purpose pin levels and counts ready falls
// assumes one clock shared with the register bus
`timescale 1ns/10ps
`default_nettype none
module sdrc_pin_host
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // device outputs watched
  input  wire logic rdy_n,
  input  wire logic gp_pin_one_o,
  input  wire logic gp_pin_one_oe,
  input  wire logic gp_pin_two_o,
  input  wire logic gp_pin_two_oe,
  // levels the outside world puts on released pins
  input  wire logic ext_one,
  input  wire logic ext_two,
  // resolved pin levels and ready edge count
  output logic      gp_pin_one_i,
  output logic      gp_pin_two_i,
  output int        rdy_falls
);
  logic rdy_prev;
  // the wire follows whoever drives it
  assign gp_pin_one_i = gp_pin_one_oe ? gp_pin_one_o : ext_one;
  assign gp_pin_two_i = gp_pin_two_oe ? gp_pin_two_o : ext_two;
  // completion is a falling edge, not a level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdy_prev  <= 1'b1;
      rdy_falls <= 0;
    end
    else
    begin
      rdy_prev <= rdy_n;
      if (rdy_prev && !rdy_n)
        rdy_falls <= rdy_falls + 1;
    end
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench: ahb-lite master tasks and one task per scenario
// assumes CAL_NS of 20, so a calibration lasts 5 clocks
`timescale 1ns/10ps
`default_nettype none
`include "sdrc_cfg.svh"
module tb;
  import sdrc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, conv_err, conv_lock, conv_data_ready;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic hreadyout, hresp, rdy_n, ext_one, ext_two, clk_en;
  logic [7:0] conv_ctrl;
  logic [3:0] conv_pin_map;
  logic conv_chop, conv_ref_sel, conv_osc_pd;
  logic p1_i, p2_i, p1_o, p1_oe, p2_o, p2_oe;
  int rdy_falls, failures, num_checks, cyc;
  sdrc_ctrl #(.CAL_NS(20)) i_sdrc_ctrl
  (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .conv_err(conv_err),
   .conv_lock(conv_lock), .conv_data_ready(conv_data_ready),
   .conv_ctrl(conv_ctrl), .conv_pin_map(conv_pin_map),
   .conv_chop(conv_chop), .conv_ref_sel(conv_ref_sel),
   .conv_osc_pd(conv_osc_pd), .rdy_n(rdy_n), .gp_pin_one_i(p1_i),
   .gp_pin_two_i(p2_i), .gp_pin_one_o(p1_o), .gp_pin_one_oe(p1_oe),
   .gp_pin_two_o(p2_o), .gp_pin_two_oe(p2_oe));
  sdrc_pin_host i_sdrc_pin_host
  (.hclk(hclk), .hresetn(hresetn), .rdy_n(rdy_n), .gp_pin_one_o(p1_o),
   .gp_pin_one_oe(p1_oe), .gp_pin_two_o(p2_o), .gp_pin_two_oe(p2_oe),
   .ext_one(ext_one), .ext_two(ext_two), .gp_pin_one_i(p1_i),
   .gp_pin_two_i(p2_i), .rdy_falls(rdy_falls));
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic close_out();
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp, logic [31:0] m);
    num_checks++;
    if ((got & m) !== (exp & m))
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // address phase held until hready, then data phase held until hready
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] exp, logic [31:0] m);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask
  task automatic t_reset_values();
    rd_chk(`SDRC_OFF_MODE, 32'h0, 32'hffffffff);
    rd_chk(`SDRC_OFF_ZSCAL, 32'h8000, 32'hffffffff);
    rd_chk(`SDRC_OFF_FSCAL, 32'h5000, 32'hf000);
    chk({31'h0, rdy_n}, 32'h1, 32'h1);
  endtask
  task automatic t_coeffs();
    xfer(1'b1, `SDRC_OFF_MODE, 32'h0);
    xfer(1'b1, `SDRC_OFF_ZSCAL, 32'h1234);
    xfer(1'b1, `SDRC_OFF_FSCAL, 32'hedcb);
    rd_chk(`SDRC_OFF_ZSCAL, 32'h1234, 32'hffffffff);
    rd_chk(`SDRC_OFF_FSCAL, 32'hedcb, 32'hffffffff);
    xfer(1'b1, `SDRC_OFF_FILT, 32'h0d);
    rd_chk(`SDRC_OFF_FILT, 32'h0d, 32'hff);
    rd_chk(8'h40, 32'h0, 32'hffffffff);
  endtask
  task automatic t_ctrl_mode();
    xfer(1'b1, `SDRC_OFF_CTRL, 32'ha5);
    rd_chk(`SDRC_OFF_CTRL, 32'ha5, 32'hffffffff);
    chk({24'h0, conv_ctrl}, 32'ha5, 32'hff);
    xfer(1'b1, `SDRC_OFF_MODE, 32'hb8);
    rd_chk(`SDRC_OFF_MODE, 32'hb8, 32'hff);
    chk({conv_pin_map, conv_chop, conv_ref_sel, conv_osc_pd}, 7'h57,
        7'h7f);
    xfer(1'b1, `SDRC_OFF_MODE, 32'h0);
    @(posedge hclk);
    chk({conv_pin_map, conv_chop, conv_ref_sel, conv_osc_pd}, 7'h10,
        7'h7f);
  endtask
  // a bus write while the enable is low must leave the register alone
  task automatic t_freeze();
    clk_en <= 1'b0;
    xfer(1'b1, `SDRC_OFF_CTRL, 32'h5a);
    clk_en <= 1'b1;
    rd_chk(`SDRC_OFF_CTRL, 32'ha5, 32'hff);
  endtask
  task automatic t_pins();
    ext_one <= 1'b0; ext_two <= 1'b1;
    xfer(1'b1, `SDRC_OFF_IOCTL, 32'h32);
    // pin registers trail the io register by one clock
    repeat (2) @(posedge hclk);
    chk({p1_oe, p1_o, p2_oe, p2_o}, 4'he, 4'hf);
    rd_chk(`SDRC_OFF_IOCTL, 32'h32, 32'hff);
    xfer(1'b1, `SDRC_OFF_IOCTL, 32'h11);
    repeat (2) @(posedge hclk);
    chk({p1_oe, p2_oe, p2_o}, 3'h3, 3'h7);
    rd_chk(`SDRC_OFF_IOCTL, 32'h11, 32'h33);
    xfer(1'b1, `SDRC_OFF_IOCTL, 32'h0);
    ext_one <= 1'b1; ext_two <= 1'b0;
    @(posedge hclk);
    rd_chk(`SDRC_OFF_IOCTL, 32'h2, 32'h33);
  endtask
  task automatic t_status();
    conv_data_ready <= 1'b1; conv_err <= 1'b0; conv_lock <= 1'b1;
    xfer(1'b1, `SDRC_OFF_STATUS, 32'hff);
    rd_chk(`SDRC_OFF_STATUS, 32'h81, 32'h89);
    conv_data_ready <= 1'b0; conv_err <= 1'b1; conv_lock <= 1'b0;
    @(posedge hclk);
    rd_chk(`SDRC_OFF_STATUS, 32'h08, 32'h89);
  endtask
  // every calibration code, back to back; the host waits for the fall
  task automatic t_cal();
    int n;
    int w;
    for (int m = 4; m < 8; m++)
    begin
      n = rdy_falls;
      xfer(1'b1, `SDRC_OFF_MODE, 32'(m));
      @(posedge hclk);
      chk({31'h0, rdy_n}, 32'h1, 32'h1);
      w = 0;
      while (rdy_n !== 1'b0 && w < 40)
      begin
        @(posedge hclk);
        w++;
      end
      // the edge counter updates one clock after the fall is seen
      repeat (2) @(posedge hclk);
      chk(32'(rdy_falls - n), 32'h1, 32'hffffffff);
      rd_chk(`SDRC_OFF_MODE, 32'h0, 32'h7);
    end
    rd_chk(`SDRC_OFF_STATUS, 32'h20, 32'h20);
    xfer(1'b1, `SDRC_OFF_DONE, 32'h1);
    rd_chk(`SDRC_OFF_STATUS, 32'h0, 32'h20);
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      close_out();
    end
  end
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 8'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; conv_err = 1'b0;
    conv_lock = 1'b0; conv_data_ready = 1'b0; ext_one = 1'b0;
    ext_two = 1'b0; failures = 0; num_checks = 0; cyc = 0;
    clk_en = 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_coeffs();
    t_ctrl_mode();
    t_freeze();
    t_pins();
    t_status();
    t_cal();
    close_out();
  end
endmodule
`default_nettype wire
